/* pkg/arl_timer_regs.svh */
// Register offsets, field positions and reset values of the auto-reload timer
`ifndef ARL_TIMER_REGS_SVH
`define ARL_TIMER_REGS_SVH

// ------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------
`define IDX_MODE_CONTROL   8'hE5
`define IDX_FLAG_STATUS    8'hE6
`define IDX_CLOCK_CONFIG   8'hE7
`define IDX_RELOAD_VALUE   8'hE9
`define IDX_COMPARE_VALUE  8'hEA
`define IDX_LOAD_PORT      8'hEB

// ------------------------------------------------------------
// Mode control fields
// ------------------------------------------------------------
`define MODE_LOAD_CMD_BIT  7
`define MODE_COUNT_EN_BIT  6
`define MODE_CMP_IE_BIT    3
`define MODE_OVF_IE_BIT    2
`define MODE_RESET         8'h00

// ------------------------------------------------------------
// Flag status fields
// ------------------------------------------------------------
`define FLAG_CMP_BIT       1
`define FLAG_OVF_BIT       0

// ------------------------------------------------------------
// Clock configuration fields
// ------------------------------------------------------------
`define CFG_PS_MSB         7
`define CFG_PS_LSB         5
`define CFG_SRC_MSB        1
`define CFG_SRC_LSB        0
`define SRC_INTERNAL       2'h0
`define SRC_INTERNAL_DIV3  2'h1
`define DIV3_LAST          2'h2

// ------------------------------------------------------------
// Reset values of data registers, and the counter top value
// ------------------------------------------------------------
`define COUNTER_RESET      8'h00
`define DATA_RESET         8'h00
`define COUNTER_TOP        8'hFF

`endif

/* pkg/arl_timer_pkg.sv */
// Types shared by the auto-reload timer design
`default_nettype none
package arl_timer_pkg;

	// Avalon-MM request from the bus master
	typedef struct packed {
		logic [9:0]  address;
		logic        read;
		logic        write;
		logic [31:0] writedata;
		logic [3:0]  byteenable;
	} avs_req_t;

endpackage : arl_timer_pkg
`default_nettype wire

/* rtl/arl_timer.sv */
// Auto-reload 8-bit timer with prescaler, compare and Avalon-MM registers
`timescale 1ns/10ps
`default_nettype none
`include "arl_timer_regs.svh"

// How it works
// RQ1 - Counter increments on each prescaler output
// RQ2 - Overflow reloads counter from reload register
// RQ3 - Overflow flag set on FFh to 00h
// RQ4 - Overflow request needs flag and enable
// RQ5 - Compare flag set when counter equals compare
// RQ6 - Compare request needs flag and enable
// RQ7 - Flags cleared by writing zero only
// RQ8 - Software keeps compare within reload..255
// RQ9 - Load bit copies reload, reads zero
// RQ10 - Count enable clear freezes counter, prescaler
// RQ11 - Every counter load clears the prescaler
// RQ12 - Prescaler select gives ratio two power n
// RQ13 - Source select: internal or internal/3
// RQ14 - Load port reads/writes running counter
// RQ15 - Reset leaves load port contents alone
// RQ16 - Reset clears mode control to 00h
// RQ17 - Software writes zero to reserved bits
// RQ18 - Software avoids clock changes while counting
// RQ19 - Software writes reload, then load+enable
// RQ20 - Reset clears the counter
// RQ21 - Load port write copies into counter
// RQ22 - Unused flag bits read zero
module arl_timer (
	input  wire logic                     ref_clk_i,
	input  wire logic                     arst_n_i,
	input  wire arl_timer_pkg::avs_req_t  avs_req_i,
	output logic [31:0]                   avs_readdata_o,
	output logic                          avs_waitrequest_o,
	output logic                          ovf_irq_o,
	output logic                          cmp_irq_o
);
	import arl_timer_pkg::*;

	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	logic       count_clock_enable;
	logic       compare_irq_enable;
	logic       overflow_irq_enable;
	logic       overflow_flag;
	logic       compare_flag;
	logic [2:0] prescale_select;
	logic [1:0] clock_source_select;
	logic [7:0] reload_value;
	logic [7:0] compare_value;
	logic [7:0] counter_load_port;
	logic [7:0] reload_counter;
	logic [6:0] timer_prescaler;
	logic [1:0] div3_count;
	logic       bus_ack;

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	wire        bus_req    = avs_req_i.read | avs_req_i.write;
	wire [7:0]  reg_idx    = avs_req_i.address[9:2];
	wire        lane0      = avs_req_i.byteenable[0];
	wire [7:0]  wdata      = avs_req_i.writedata[7:0];
	wire        wr_commit  = avs_req_i.write & bus_ack & lane0;
	wire        rd_sample  = avs_req_i.read & ~bus_ack;
	wire        wr_mode    = wr_commit & (reg_idx == `IDX_MODE_CONTROL);
	wire        wr_flags   = wr_commit & (reg_idx == `IDX_FLAG_STATUS);
	wire        wr_config  = wr_commit & (reg_idx == `IDX_CLOCK_CONFIG);
	wire        wr_reload  = wr_commit & (reg_idx == `IDX_RELOAD_VALUE);
	wire        wr_compare = wr_commit & (reg_idx == `IDX_COMPARE_VALUE);
	wire        wr_loadreg = wr_commit & (reg_idx == `IDX_LOAD_PORT);

	// One wait state: request seen, then answered on the next edge
	assign avs_waitrequest_o = bus_req & ~bus_ack;

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			bus_ack <= 1'b0;
		end else begin
			bus_ack <= bus_req & ~bus_ack;
		end
	end

	// ------------------------------------------------------------
	// Read multiplexer
	// ------------------------------------------------------------
	wire [7:0] mode_rd  = {1'b0, count_clock_enable, 2'b00,
		compare_irq_enable, overflow_irq_enable, 2'b00}; // [RQ9]
	wire [7:0] flag_rd  = {6'h00, compare_flag, overflow_flag}; // [RQ22]
	wire [7:0] cfg_rd   = {prescale_select, 3'h0, clock_source_select};
	logic [7:0] rd_byte;

	always_comb begin
		unique case (reg_idx)
			`IDX_MODE_CONTROL:  rd_byte = mode_rd;
			`IDX_FLAG_STATUS:   rd_byte = flag_rd;
			`IDX_CLOCK_CONFIG:  rd_byte = cfg_rd;
			`IDX_RELOAD_VALUE:  rd_byte = reload_value;
			`IDX_COMPARE_VALUE: rd_byte = compare_value;
			`IDX_LOAD_PORT:     rd_byte = reload_counter; // [RQ14]
			default:            rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			avs_readdata_o <= 32'h0000_0000;
		end else if (rd_sample) begin
			avs_readdata_o <= {24'h00_0000, rd_byte};
		end
	end

	// ------------------------------------------------------------
	// Control and data registers
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			count_clock_enable  <= 1'b0; // [RQ16]
			compare_irq_enable  <= 1'b0;
			overflow_irq_enable <= 1'b0;
		end else if (wr_mode) begin
			count_clock_enable  <= wdata[`MODE_COUNT_EN_BIT];
			compare_irq_enable  <= wdata[`MODE_CMP_IE_BIT];
			overflow_irq_enable <= wdata[`MODE_OVF_IE_BIT];
		end
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			prescale_select     <= 3'h0;
			clock_source_select <= `SRC_INTERNAL;
		end else if (wr_config) begin
			prescale_select     <= wdata[`CFG_PS_MSB:`CFG_PS_LSB]; // [RQ12]
			clock_source_select <= wdata[`CFG_SRC_MSB:`CFG_SRC_LSB];
		end
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			reload_value  <= `DATA_RESET;
			compare_value <= `DATA_RESET;
		end else begin
			if (wr_reload) begin
				reload_value <= wdata;
			end
			if (wr_compare) begin
				compare_value <= wdata;
			end
		end
	end

	// Holding copy of the last load-port write; kept across reset
	always_ff @(posedge ref_clk_i) begin
		if (wr_loadreg) begin
			counter_load_port <= wdata; // [RQ15]
		end
	end

	// ------------------------------------------------------------
	// Clock source and prescaler
	// ------------------------------------------------------------
	wire load_cmd  = wr_mode & wdata[`MODE_LOAD_CMD_BIT];
	wire any_load  = load_cmd | wr_loadreg;
	wire run       = count_clock_enable & ~any_load; // [RQ10]
	// Reserved source codes give no ticks, so the timer stays put
	wire src_tick  = (clock_source_select == `SRC_INTERNAL) |
		((clock_source_select == `SRC_INTERNAL_DIV3) &
		(div3_count == `DIV3_LAST)); // [RQ13]
	wire [6:0] ps_mask  = ~7'(7'h7F << prescale_select);
	wire tap_hit   = (timer_prescaler & ps_mask) == ps_mask; // [RQ12]
	wire cnt_tick  = run & src_tick & tap_hit; // [RQ1]

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			div3_count <= 2'h0;
		end else if (any_load) begin
			div3_count <= 2'h0;
		end else if (run) begin
			div3_count <= (div3_count == `DIV3_LAST) ? 2'h0 : div3_count + 2'h1;
		end
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			timer_prescaler <= 7'h00;
		end else if (any_load | (cnt_tick & (reload_counter == `COUNTER_TOP))) begin
			// Auto-reload counts as a load, so it restarts the prescaler too
			timer_prescaler <= 7'h00; // [RQ11]
		end else if (run & src_tick) begin
			timer_prescaler <= timer_prescaler + 7'h01;
		end
	end

	// ------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------
	wire       at_top     = reload_counter == `COUNTER_TOP;
	wire       overflow   = cnt_tick & at_top;
	logic [7:0] next_counter;

	always_comb begin
		if (wr_loadreg) begin
			next_counter = wdata; // [RQ21]
		end else if (load_cmd) begin
			next_counter = reload_value; // [RQ9]
		end else if (overflow) begin
			next_counter = reload_value; // [RQ2]
		end else if (cnt_tick) begin
			next_counter = reload_counter + 8'h01; // [RQ1]
		end else begin
			next_counter = reload_counter;
		end
	end

	wire cnt_moves = any_load | cnt_tick;
	wire cmp_hit   = cnt_moves & (next_counter == compare_value); // [RQ5]

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			reload_counter <= `COUNTER_RESET; // [RQ20]
		end else begin
			reload_counter <= next_counter;
		end
	end

	// ------------------------------------------------------------
	// Flags and requests
	// ------------------------------------------------------------
	// Hardware set wins over a software clear in the same cycle
	wire next_ovf = overflow | (overflow_flag &
		~(wr_flags & ~wdata[`FLAG_OVF_BIT])); // [RQ3] [RQ7]
	wire next_cmp = cmp_hit | (compare_flag &
		~(wr_flags & ~wdata[`FLAG_CMP_BIT])); // [RQ7]

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			overflow_flag <= 1'b0;
			compare_flag  <= 1'b0;
		end else begin
			overflow_flag <= next_ovf;
			compare_flag  <= next_cmp;
		end
	end

	assign ovf_irq_o = overflow_flag & overflow_irq_enable; // [RQ4]
	assign cmp_irq_o = compare_flag & compare_irq_enable; // [RQ6]

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!arst_n_i);

	property p_increment;
		cnt_tick & ~at_top |=> reload_counter == $past(reload_counter) + 8'h01;
	endproperty
	a_increment: assert property (p_increment) // [RQ1]
		else $error("counter did not step by one");

	property p_reload;
		overflow & ~any_load |=> reload_counter == $past(reload_value);
	endproperty
	a_reload: assert property (p_reload) // [RQ2]
		else $error("overflow did not reload");

	property p_ovf_flag;
		overflow |=> overflow_flag;
	endproperty
	a_ovf_flag: assert property (p_ovf_flag) // [RQ3]
		else $error("overflow flag not set");

	property p_ovf_irq;
		ovf_irq_o |-> overflow_flag && overflow_irq_enable;
	endproperty
	a_ovf_irq: assert property (p_ovf_irq) // [RQ4]
		else $error("overflow request not masked");

	property p_cmp_flag;
		cnt_moves && next_counter == compare_value |=> compare_flag;
	endproperty
	a_cmp_flag: assert property (p_cmp_flag) // [RQ5]
		else $error("compare flag not set");

	property p_cmp_irq;
		compare_flag && compare_irq_enable |-> cmp_irq_o;
	endproperty
	a_cmp_irq: assert property (p_cmp_irq) // [RQ6]
		else $error("compare request missing");

	property p_flag_hold;
		overflow_flag && !(wr_flags && !wdata[0]) |=> overflow_flag;
	endproperty
	a_flag_hold: assert property (p_flag_hold) // [RQ7]
		else $error("overflow flag lost without clear");

	property p_load_cmd;
		load_cmd && !wr_loadreg |=>
			reload_counter == $past(reload_value) && timer_prescaler == 7'h00;
	endproperty
	a_load_cmd: assert property (p_load_cmd) // [RQ9]
		else $error("load command failed");

	property p_freeze;
		!count_clock_enable && !$past(any_load) && !any_load
			|=> $stable(reload_counter) && $stable(timer_prescaler);
	endproperty
	a_freeze: assert property (p_freeze) // [RQ10]
		else $error("stopped timer moved");

	property p_load_port;
		wr_loadreg |=> reload_counter == $past(wdata) && timer_prescaler == 7'h00;
	endproperty
	a_load_port: assert property (p_load_port) // [RQ21]
		else $error("load port write lost");

	property p_mode_read;
		avs_req_i.read && bus_ack && $past(reg_idx) == `IDX_MODE_CONTROL
			|-> avs_readdata_o[7] == 1'b0;
	endproperty
	a_mode_read: assert property (p_mode_read) // [RQ9]
		else $error("load bit read as one");

	property p_flag_read;
		avs_req_i.read && bus_ack |-> avs_readdata_o[31:8] == 24'h00_0000;
	endproperty
	a_flag_read: assert property (p_flag_read) // [RQ22]
		else $error("upper read bits not zero");

	property p_ovf_clear;
		overflow_flag && wr_flags && !wdata[`FLAG_OVF_BIT] && !overflow |=> !overflow_flag;
	endproperty
	a_ovf_clear: assert property (p_ovf_clear) // [RQ7]
		else $error("overflow flag not cleared by zero write");

	property p_cmp_clear;
		compare_flag && wr_flags && !wdata[`FLAG_CMP_BIT] && !cmp_hit |=> !compare_flag;
	endproperty
	a_cmp_clear: assert property (p_cmp_clear) // [RQ7]
		else $error("compare flag not cleared by zero write");

	property p_prescale_clear;
		any_load || overflow |=> timer_prescaler == 7'h00;
	endproperty
	a_prescale_clear: assert property (p_prescale_clear) // [RQ11]
		else $error("prescaler not cleared on load");

	property p_cfg_keep;
		wr_config && !(run && src_tick) |=> $stable(timer_prescaler);
	endproperty
	a_cfg_keep: assert property (p_cfg_keep) // [RQ12]
		else $error("select write moved the prescaler");

	property p_no_src;
		clock_source_select[1] |-> !cnt_tick;
	endproperty
	a_no_src: assert property (p_no_src) // [RQ13]
		else $error("reserved source produced a tick");

	property p_div3;
		clock_source_select == `SRC_INTERNAL_DIV3 && cnt_tick |-> div3_count == `DIV3_LAST;
	endproperty
	a_div3: assert property (p_div3) // [RQ13]
		else $error("divided source ticked off phase");

	property p_load_hold;
		wr_loadreg |=> counter_load_port == $past(wdata);
	endproperty
	a_load_hold: assert property (p_load_hold) // [RQ15]
		else $error("load port copy not kept");

	c_overflow: cover property (overflow ##1 ovf_irq_o);
	c_compare:  cover property (cmp_hit ##1 cmp_irq_o);
	c_load:     cover property (load_cmd ##[1:20] cnt_tick);
	c_read:     cover property (rd_sample ##1 !avs_waitrequest_o);
	c_div3:     cover property (clock_source_select == `SRC_INTERNAL_DIV3 && cnt_tick);

endmodule : arl_timer
`default_nettype wire

/* verif/testbench.sv */
// Self-checking testbench for the auto-reload timer
`timescale 1ns/10ps
`default_nettype none
`include "arl_timer_regs.svh"
module testbench;
	import arl_timer_pkg::*;
	logic        ref_clk_i;
	logic        arst_n_i;
	avs_req_t    req;
	logic [31:0] rdata;
	logic        wait_req;
	logic        ovf_irq;
	logic        cmp_irq;
	logic [7:0]  exp_q[$];
	logic [7:0]  e_m;
	int          mismatches;
	int          n_tests;

	arl_timer i_arl_timer (
		.ref_clk_i        (ref_clk_i),
		.arst_n_i         (arst_n_i),
		.avs_req_i        (req),
		.avs_readdata_o   (rdata),
		.avs_waitrequest_o(wait_req),
		.ovf_irq_o        (ovf_irq),
		.cmp_irq_o        (cmp_irq)
	);

	initial begin
		ref_clk_i = 1'b0;
		forever #50 ref_clk_i = ~ref_clk_i;
	end

	// ------------------------------------------------------------
	// Closing report and checks
	// ------------------------------------------------------------
	task automatic print_verdict();
		$display("Checks %0d, mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : print_verdict

	// Level is read mid-cycle, not when the call is made
	task automatic chk(input logic cmp_side, input logic e);
		logic got;
		@(negedge ref_clk_i);
		got = cmp_side ? cmp_irq : ovf_irq;
		n_tests++;
		if (got !== e) begin
			mismatches++;
			$display("BAD t=%0t exp=%h got=%h", $time, e, got);
		end
	endtask : chk

	// Readdata is taken at the rising edge that sees waitrequest low
	always @(posedge ref_clk_i) begin
		if (req.read === 1'b1 && wait_req === 1'b0 && exp_q.size() > 0) begin
			e_m = exp_q.pop_front();
			n_tests++;
			if (rdata !== {24'h000000, e_m}) begin
				mismatches++;
				$display("BAD t=%0t exp=%h got=%h", $time, e_m, rdata);
			end
		end
	end

	// ------------------------------------------------------------
	// Avalon-MM master
	// ------------------------------------------------------------
	task automatic bus(input logic rd, input logic [7:0] idx, input logic [7:0] d,
		input logic [3:0] be);
		int k;
		@(posedge ref_clk_i);
		req.address    <= {idx, 2'b00};
		req.read       <= rd;
		req.write      <= ~rd;
		req.writedata  <= {24'h000000, d};
		req.byteenable <= be;
		// Request stands until the rising edge that samples waitrequest low
		for (k = 0; k < 16; k++) begin
			@(posedge ref_clk_i);
			if (wait_req === 1'b0) break;
		end
		if (k == 16) begin
			mismatches++;
			print_verdict();
		end else begin
			req.read  <= 1'b0;
			req.write <= 1'b0;
		end
	endtask : bus

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		bus(1'b0, idx, d, 4'hF);
	endtask : wr

	task automatic rd(input logic [7:0] idx, input logic [7:0] e);
		exp_q.push_back(e);
		bus(1'b1, idx, 8'h00, 4'hF);
	endtask : rd

	// ------------------------------------------------------------
	// One timed run: load, count for a random span, stop, check
	// ------------------------------------------------------------
	task automatic run(input int i);
		logic [1:0] src;
		logic [2:0] ps;
		logic [1:0] ie;
		logic [7:0] v;
		logic [7:0] mie;
		logic [7:0] rld;
		logic [7:0] cmpv;
		logic [7:0] cnt;
		logic       ovf;
		logic       cmpf;
		int         w;
		int         steps;
		src  = i[1:0];
		ps   = i[4:2];
		ie   = 2'($urandom_range(0, 3));
		rld  = 8'($urandom);
		cmpv = rld + 8'($urandom_range(0, 255 - int'(rld)));
		v    = 8'($urandom);
		w    = $urandom_range(0, 300);
		mie  = {4'h0, ie, 2'b00};
		wr(`IDX_FLAG_STATUS, 8'h00);
		wr(`IDX_RELOAD_VALUE, rld);
		wr(`IDX_COMPARE_VALUE, cmpv);
		wr(`IDX_CLOCK_CONFIG, {ps, 3'b000, src});
		if (i[5]) begin
			v = rld;
			wr(`IDX_MODE_CONTROL, 8'hC0 | mie);
		end else begin
			wr(`IDX_LOAD_PORT, v);
			wr(`IDX_MODE_CONTROL, 8'h40 | mie);
		end
		repeat (w) @(posedge ref_clk_i);
		wr(`IDX_MODE_CONTROL, mie);
		// Enable to disable spans w+3 edges; reserved sources give no ticks
		steps = (src == 2'd0) ? w + 3 : (src == 2'd1) ? (w + 3) / 3 : 0;
		steps = steps >> ps;
		cnt   = v;
		ovf   = 1'b0;
		cmpf  = (v == cmpv);
		repeat (steps) begin
			if (cnt == `COUNTER_TOP) begin
				cnt = rld;
				ovf = 1'b1;
			end else begin
				cnt = cnt + 8'h01;
			end
			if (cnt == cmpv) cmpf = 1'b1;
		end
		rd(`IDX_LOAD_PORT, cnt);
		rd(`IDX_FLAG_STATUS, {6'h00, cmpf, ovf});
		rd(`IDX_MODE_CONTROL, mie);
		rd(`IDX_CLOCK_CONFIG, {ps, 3'b000, src});
		chk(1'b0, ovf & ie[0]);
		chk(1'b1, cmpf & ie[1]);
		wr(`IDX_FLAG_STATUS, 8'hFE);
		rd(`IDX_FLAG_STATUS, {6'h00, cmpf, 1'b0});
		chk(1'b0, 1'b0);
		chk(1'b1, cmpf & ie[1]);
	endtask : run

	initial begin
		mismatches = 0;
		n_tests    = 0;
		arst_n_i   = 1'b0;
		req        = '0;
		void'($urandom(28826));
		repeat (2) @(posedge ref_clk_i);
		arst_n_i <= 1'b1;
		rd(`IDX_MODE_CONTROL, `MODE_RESET);
		rd(`IDX_LOAD_PORT, `COUNTER_RESET);
		rd(`IDX_FLAG_STATUS, 8'h00);
		// Unmapped place and a write with lane 0 disabled are both dropped
		wr(8'hE8, 8'h5A);
		rd(8'hE8, 8'h00);
		wr(`IDX_RELOAD_VALUE, 8'h33);
		bus(1'b0, `IDX_RELOAD_VALUE, 8'hCC, 4'hE);
		rd(`IDX_RELOAD_VALUE, 8'h33);
		for (int i = 0; i < 64; i++) begin
			run(i);
		end
		// Reset with count enable set (last run left a reserved source, so no ticks) must clear mode and counter again
		wr(`IDX_MODE_CONTROL, 8'hC0);
		repeat (5) @(posedge ref_clk_i);
		arst_n_i <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
		arst_n_i <= 1'b1;
		rd(`IDX_MODE_CONTROL, `MODE_RESET);
		rd(`IDX_LOAD_PORT, `COUNTER_RESET);
		rd(`IDX_FLAG_STATUS, 8'h00);
		repeat (2) @(posedge ref_clk_i);
		print_verdict();
	end
endmodule : testbench
`default_nettype wire
